// *** dv/adc_control_sequencer_bench.sv ***
`timescale 1ns/1ps
module adc_control_sequencer_bench;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  converter_control_reg_t ctrl = '0;
  converter_clock_select_reg_t clk_sel = '0;
  logic [7:0] dir_reg = 8'h5A;
  logic [7:0] pull_opt = 8'hC3;
  logic [11:0] core_data, lvl;
  logic [7:0] ain, dir_eff, pull;
  logic tick_en, core_rst, pwr_on, pending, irq;
  result_t res;
  int fail_count = 0;
  int checked = 0;
  // {pin code, channel, divider, routed channel, analog pin mask}
  logic [23:0] rows [4] = '{24'hFF80FF, 24'h200101, 24'h8D080F, 24'hD6203F};
  initial forever #50 clk = ~clk;
  adc_control_sequencer uut (.clk(clk), .nrst(nrst), .ctrl(ctrl), .clk_sel(clk_sel),
    .port_b_direction_reg(dir_reg), .pull_high_enable(pull_opt), .core_data(core_data),
    .analog_inputs_en(ain), .port_b_dir_eff(dir_eff), .port_b_pull_en(pull),
    .conv_clk_en(tick_en), .core_reset(core_rst), .core_power_on(pwr_on),
    .conversion_pending_flag(pending), .result(res), .conv_irq(irq));
  analog_source_model src (.clk(clk), .analog_inputs_en(ain), .core_data(core_data));
  task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // a long hold keeps the converter in reset before the conversion runs
  task automatic convert(input logic [7:0] cfg, input int hold);
    int ticks;
    ticks = 0;
    {ctrl.pin_analog_config_field, ctrl.channel_select_field, clk_sel} = cfg;
    step(4);
    ctrl.start = 1'b1;
    step(hold);
    check("held", {core_rst, pending}, 25'h3);
    ctrl.start = 1'b0;
    for (int i = 0; i < 400 && pending !== 1'b0; i++) begin
      step(1);
      if (pending === 1'b1) ticks += int'(tick_en);
    end
    check("done", pending, 25'h0);
    if (pending !== 1'b0) conclude();
    check("irq", irq, 25'h1);
    check("ticks", 25'(ticks), 25'(CONV_PERIODS));
    lvl = 12'h1E7 + 12'(ctrl.channel_select_field) * 12'h321;
    check("result", res, {lvl, 4'h0});
    step(1);
    check("irq_end", irq, 25'h0);
  endtask
  initial begin
    step(2);
    check("reset", {core_rst, pending, res}, 25'h30000);
    nrst = 1'b1;
    foreach (rows[r]) begin
      convert(rows[r][23:16], 2);
      check("route", ain, rows[r][15:8]);
      check("dir", dir_eff, dir_reg | rows[r][7:0]);
      check("pull", pull, pull_opt & ~rows[r][7:0]);
    end
    convert(8'hFF, 40);
    // channel change mid conversion with no restart must not report a false end
    ctrl.start = 1'b1;
    step(1);
    ctrl.start = 1'b0;
    step(3);
    ctrl.channel_select_field = 3'h2;
    step(200);
    check("stale", {pending, irq}, 25'h2);
    ctrl.pin_analog_config_field = 3'h0;
    step(2);
    check("off", {pwr_on, ain, dir_eff, pull}, {1'b0, 8'h00, dir_reg, pull_opt});
    conclude();
  end
endmodule

// *** dv/adc_control_sequencer_properties.sv ***
`timescale 1ns/1ps
module adc_control_sequencer_properties
  import adc_ctrl_pkg::*;
(
  // clock, reset and inputs
  input wire logic clk,
  input wire logic nrst,
  input wire adc_ctrl_pkg::converter_control_reg_t ctrl,
  input wire adc_ctrl_pkg::converter_clock_select_reg_t clk_sel,
  input wire logic [7:0] pull_high_enable,
  input wire logic [11:0] core_data,
  // outputs
  input wire logic [7:0] analog_inputs_en,
  input wire logic [7:0] port_b_pull_en,
  input wire logic conv_clk_en,
  input wire logic core_power_on,
  input wire logic conversion_pending_flag,
  input wire adc_ctrl_pkg::result_t result,
  input wire logic conv_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] pc;
  logic [7:0] msk;
  logic [4:0] div, gap_q, ticks_q;
  assign pc = ctrl.pin_analog_config_field;
  assign msk = (pc == 3'h7) ? 8'hFF : 8'((9'h001 << pc) - 9'h001);
  assign div = (clk_sel == 2'h3) ? 5'h0C : 5'h04 + {2'h0, clk_sel, 1'b0};
  // the gap restarts on a divider or power change, where the first period may be short
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 5'h00;
      ticks_q <= 5'h00;
    end else begin
      gap_q <= conv_clk_en ? 5'h01 : ($changed(clk_sel) || $changed(core_power_on)
               || gap_q == 5'h00) ? 5'h00 : gap_q + 5'h01;
      ticks_q <= $fell(ctrl.start) ? 5'h00 : ticks_q + 5'(conv_clk_en);
    end
  end
  property p_pull; $past(nrst) |-> port_b_pull_en == ($past(pull_high_enable) & ~$past(msk)); endproperty
  a_pull: assert property (p_pull) else $error("pull enable wrong");
  property p_route; $past(nrst) |-> analog_inputs_en == ($past(msk)
    & (8'h01 << $past(ctrl.channel_select_field))); endproperty
  a_route: assert property (p_route) else $error("channel route wrong");
  property p_pwr; $past(nrst) |-> core_power_on == ($past(pc) != 3'h0); endproperty
  a_pwr: assert property (p_pwr) else $error("power state wrong");
  property p_rise; $rose(ctrl.start) && pc != 3'h0 |-> ##[1:2] conversion_pending_flag; endproperty
  a_rise: assert property (p_rise) else $error("flag not set by start");
  property p_hold; ctrl.start && $past(ctrl.start) && $past(ctrl.start, 2) && pc != 3'h0
    |-> conversion_pending_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag low while start held");
  property p_irq; conv_irq == $fell(conversion_pending_flag); endproperty
  a_irq: assert property (p_irq) else $error("request not tied to completion");
  property p_res; $fell(conversion_pending_flag) |-> result == {$past(core_data), 4'h0}; endproperty
  a_res: assert property (p_res) else $error("result layout wrong");
  property p_len; $fell(conversion_pending_flag) |-> ticks_q == CONV_PERIODS; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_div; conv_clk_en && gap_q != 5'h00 |-> gap_q == div; endproperty
  a_div: assert property (p_div) else $error("conversion clock period wrong");
  c_done: cover property ($fell(conversion_pending_flag));
  c_hold: cover property (ctrl.start && $past(ctrl.start, 8));
  c_off: cover property ($fell(core_power_on));
endmodule
bind adc_control_sequencer adc_control_sequencer_properties chk (.*);

// *** dv/analog_source_model.sv ***
`timescale 1ns/1ps
module analog_source_model (
  // routing in, sample out
  input  wire logic        clk,
  input  wire logic [7:0]  analog_inputs_en,
  output logic      [11:0] core_data
);
  logic [11:0] float_q = 12'h000;
  // an unrouted input floats, so it toggles rather than keep a plausible value
  always_ff @(posedge clk) float_q <= ~float_q;
  always_comb begin
    core_data = float_q;
    for (int i = 0; i < 8; i++)
      if (analog_inputs_en[i]) core_data = 12'h1E7 + 12'(i) * 12'h321;
  end
endmodule

// *** rtl/adc_control_sequencer.sv ***
// Operation
// - conversion clock is oscillator divided by 4, 6, 8 or 12 per divider code
// - only the selected channel's analog input reaches the converter
// - pin field enables analog pins growing from lowest; 000 none, 111 all
// - pin function changes at run time only by rewriting the pin field
// - direction register is ignored for pins assigned to analog input
// - pull-high is disconnected on analog pins and restored on ordinary I/O
// - pending flag undefined after channel change until start pulse, then high
// - a low-high-low start sequence begins a conversion
// - pending flag goes low on completion; result bytes then hold valid data
// - bits 11..4 in high byte, bits 3..0 in low byte bits 7..4
// - start held high keeps converter reset with pending flag high
// - conversion end raises the converter interrupt request
// - pin field all zero powers down the converter
`timescale 1ns/1ps
module adc_control_sequencer
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     nrst,
  // control registers
  input  wire adc_ctrl_pkg::converter_control_reg_t     ctrl,
  input  wire adc_ctrl_pkg::converter_clock_select_reg_t clk_sel,
  // port b controls and pins
  input  wire logic [7:0]                               port_b_direction_reg,
  input  wire logic [7:0]                               pull_high_enable,
  // converter core and port b pin outputs
  input  wire logic [11:0]                              core_data,
  output logic [7:0]                                    analog_inputs_en,
  output logic [7:0]                                    port_b_dir_eff,
  output logic [7:0]                                    port_b_pull_en,
  output logic                                          conv_clk_en,
  output logic                                          core_reset,
  output logic                                          core_power_on,
  // status
  output logic                                          conversion_pending_flag,
  output adc_ctrl_pkg::result_t                         result,
  output logic                                          conv_irq
);
  import adc_ctrl_pkg::*;

  logic [3:0]  div_cnt_q;
  logic [3:0]  div_cnt_d;
  logic [3:0]  div_max;
  logic        tick_q;
  logic        tick_d;
  logic        start_q;
  logic        start_d;
  logic [2:0]  chan_q;
  logic [2:0]  chan_d;
  conv_state_t st_q;
  conv_state_t st_d;
  logic [4:0]  per_q;
  logic [4:0]  per_d;
  logic        pend_q;
  logic        pend_d;
  result_t     res_q;
  result_t     res_d;
  logic        irq_q;
  logic        irq_d;
  logic [7:0]  amask_d;
  logic [7:0]  sel_q;
  logic [7:0]  sel_d;
  logic [7:0]  dir_q;
  logic [7:0]  dir_d;
  logic [7:0]  pull_q;
  logic [7:0]  pull_d;
  logic        pwr_q;
  logic        pwr_d;
  logic        rst_q;
  logic        rst_d;

  // divider reload from the two select bits
  always_comb begin
    case ({clk_sel.conv_clk_div_sel_hi, clk_sel.conv_clk_div_sel_lo})
      DIV_SEL_4:  div_max = DIV_CNT_4;
      DIV_SEL_6:  div_max = DIV_CNT_6;
      DIV_SEL_8:  div_max = DIV_CNT_8;
      default:    div_max = DIV_CNT_12;
    endcase
  end

  always_comb begin
    tick_d    = 1'b0;
    div_cnt_d = div_cnt_q + 4'h1;
    if (div_cnt_q >= div_max) begin
      div_cnt_d = 4'h0;
      tick_d    = 1'b1;
    end
  end

  // pin sharing; recomputed every cycle so rewrites take effect on the next clock
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      amask_d[i] = (ctrl.pin_analog_config_field != 3'h0) &&
                   (ctrl.pin_analog_config_field == 3'h7 ||
                    i < 32'(ctrl.pin_analog_config_field));
    end
    sel_d  = amask_d & (8'h01 << ctrl.channel_select_field);
    dir_d  = port_b_direction_reg | amask_d;
    pull_d = pull_high_enable & ~amask_d;
    pwr_d  = (ctrl.pin_analog_config_field != 3'h0);
  end

  // conversion sequencer
  always_comb begin
    st_d    = st_q;
    per_d   = per_q;
    pend_d  = pend_q;
    res_d   = res_q;
    irq_d   = 1'b0;
    start_d = ctrl.start;
    chan_d  = ctrl.channel_select_field;
    rst_d   = 1'b0;
    case (st_q)
      ST_IDLE, ST_DONE: begin
        if (ctrl.start && !start_q) begin
          st_d = ST_RESET;
        end
      end
      ST_RESET: begin
        pend_d = 1'b1;
        rst_d  = 1'b1;
        if (!ctrl.start) begin
          st_d  = ST_CONV;
          per_d = 5'h0;
          rst_d = 1'b0;
        end
      end
      ST_CONV: begin
        if (ctrl.start) begin
          st_d   = ST_RESET;
          rst_d  = 1'b1;
        end else if (tick_q) begin
          if (per_q == CONV_PERIODS - 5'h1) begin
            st_d   = ST_DONE;
            pend_d = 1'b0;
            irq_d  = 1'b1;
            res_d.result_high_byte = core_data[11:RES_HI_LSB];
            res_d.result_low_byte  = {core_data[3:0], 4'h0};
          end else begin
            per_d = per_q + 5'h1;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // a channel change mid conversion wins over a completing tick, so no false end
    if (chan_q != ctrl.channel_select_field && st_q == ST_CONV) begin
      st_d   = ST_IDLE;
      pend_d = pend_q;
      irq_d  = 1'b0;
      res_d  = res_q;
    end
    if (!pwr_q) begin
      st_d = ST_IDLE;
    end
  end

  // divider state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= 4'h0;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
    end
  end

  // pin sharing state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q     <= 8'h00;
      dir_q     <= 8'h00;
      pull_q    <= 8'h00;
      pwr_q     <= 1'b0;
    end else begin
      sel_q     <= sel_d;
      dir_q     <= dir_d;
      pull_q    <= pull_d;
      pwr_q     <= pwr_d;
    end
  end

  // sequencer state; the core stays in reset while powered down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_q   <= 1'b0;
      chan_q    <= CHAN_RST;
      st_q      <= ST_IDLE;
      per_q     <= 5'h0;
      pend_q    <= 1'b1;
      res_q     <= '{result_high_byte: RES_BYTE_RST, result_low_byte: RES_BYTE_RST};
      irq_q     <= 1'b0;
      rst_q     <= 1'b1;
    end else begin
      start_q   <= start_d;
      chan_q    <= chan_d;
      st_q      <= st_d;
      per_q     <= per_d;
      pend_q    <= pend_d;
      res_q     <= res_d;
      irq_q     <= irq_d;
      rst_q     <= rst_d | ~pwr_d;
    end
  end

  assign analog_inputs_en        = sel_q;
  assign port_b_dir_eff          = dir_q;
  assign port_b_pull_en          = pull_q;
  assign conv_clk_en             = tick_q;
  assign core_reset              = rst_q;
  assign core_power_on           = pwr_q;
  assign conversion_pending_flag = pend_q;
  assign result                  = res_q;
  assign conv_irq                = irq_q;

endmodule

// *** rtl/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // divider select codes
  localparam logic [1:0] DIV_SEL_4  = 2'h0;
  localparam logic [1:0] DIV_SEL_6  = 2'h1;
  localparam logic [1:0] DIV_SEL_8  = 2'h2;
  localparam logic [1:0] DIV_SEL_12 = 2'h3;
  localparam logic [3:0] DIV_CNT_4  = 4'h3;
  localparam logic [3:0] DIV_CNT_6  = 4'h5;
  localparam logic [3:0] DIV_CNT_8  = 4'h7;
  localparam logic [3:0] DIV_CNT_12 = 4'hB;

  // conversion length in conversion clock periods
  localparam logic [4:0] CONV_PERIODS = 5'h10;

  // reset values
  localparam logic [2:0] CHAN_RST     = 3'h0;
  localparam logic [2:0] PINCFG_RST   = 3'h0;
  localparam logic [1:0] DIVSEL_RST   = 2'h0;
  localparam logic [7:0] RES_BYTE_RST = 8'h00;

  // result byte layout
  localparam int RES_HI_LSB = 4;
  localparam int RES_LO_POS = 4;

  typedef struct packed {
    logic [2:0] channel_select_field;
    logic [2:0] pin_analog_config_field;
    logic       start;
  } converter_control_reg_t;

  typedef struct packed {
    logic conv_clk_div_sel_hi;
    logic conv_clk_div_sel_lo;
  } converter_clock_select_reg_t;

  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } result_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_CONV, ST_DONE} conv_state_t;

endpackage
